//--- logic/qtm_pkg.sv
// Purpose: Shared constants for the quick trip threshold monitor
// Assumes: 16-bit register port, 25 MHz core clock
// Notes: Register offsets are word addresses on the plain register port
package qtm_pkg;
  // Register offsets
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_PORT = 3'h1;
  localparam logic [2:0] ADDR_LOW_LOWER = 3'h2;
  localparam logic [2:0] ADDR_HIGH_LOWER = 3'h3;
  localparam logic [2:0] ADDR_LOW_UPPER = 3'h4;
  localparam logic [2:0] ADDR_HIGH_UPPER = 3'h5;
  localparam logic [2:0] ADDR_BOUNDS = 3'h6;
  // Control register fields
  localparam int CTL_ENABLE_BIT = 12;
  localparam int CTL_LIST_BIT = 7;
  localparam int CTL_LOWHIGH_BIT = 4;
  localparam int CTL_INDEX_LSB = 0;
  // Port fields
  localparam int THR_WIDTH = 10;
  localparam int ENTRY_PAIR_BIT = 4;
  localparam int ENTRY_WIDTH = 5;
  // Bounds register fields
  localparam int BOUNDS_FIRST_LSB = 8;
  localparam int BOUNDS_LAST_LSB = 0;
  // Trip register fields
  localparam int TRIP_MASK_LSB = 8;
  // Reset values
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // Wake delay after enable
  localparam int WAKE_CLOCKS = 120;
  localparam logic [6:0] WAKE_COUNT = 7'(WAKE_CLOCKS);
  typedef enum logic [1:0] {QTM_IDLE, QTM_WAKE, QTM_LOW, QTM_HIGH} qtm_state_type;
endpackage

//--- logic/qtm_trip_bank.sv
// Purpose: Eight trip flags with their mask bits
// Assumes: Caller decodes writes to this register
// Notes: Hardware set wins over a software clear
`timescale 1ns/10ps
module qtm_trip_bank
  import qtm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wr,
  input wire logic [15:0] wdata,
  input wire logic [7:0] hw_set,
  output logic [15:0] value,
  output logic irq
);
  logic [7:0] flag_q, flag_d, mask_q, mask_d;

  // Next flags and masks
  always_comb begin
    flag_d = flag_q;
    mask_d = mask_q;
    if (wr) begin
      flag_d = wdata[7:0]; // [R12] [R13]
      mask_d = wdata[TRIP_MASK_LSB +: 8];
    end
    flag_d = flag_d | hw_set; // [R20]
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flag_q <= 8'h00;
      mask_q <= 8'h00;
    end else begin
      flag_q <= flag_d;
      mask_q <= mask_d;
    end
  end

  assign value = {mask_q, flag_q};
  assign irq = |(flag_q & mask_q); // [R7] [R9]
endmodule

//--- logic/qtm_monitor.sv
// Purpose: Register file and scan sequencer of the quick trip monitor
// Assumes: Comparator result arrives combinationally for the selected input
// Notes: Read data stand one cycle after the read strobe
// Behaviour
// [R1] Port reaches thresholds when list select is 0, scan list when 1
// [R2] Low/high select picks low or high threshold entry at the index
// [R3] Thresholds store data bits 9:0; upper bits ignored, read zero
// [R4] List entry bit 4 selects single-ended (0) or differential (1)
// [R5] List entry bits 3:0 select input; differential codes 8 and up invalid
// [R6] Low lower flags set when entries 0-7 measure below low threshold
// [R7] Low lower bits 15:8 enable interrupts for matching flags
// [R8] High lower flags set when entries 0-7 measure above high threshold
// [R9] High lower bits 15:8 mask their flags bit for bit
// [R10] Low upper register holds flags and enables for entries 8-15
// [R11] High upper register holds flags and enables for entries 8-15
// [R12] Software clears flags itself by writing zero
// [R13] Software write of one sets a flag like a trip
// [R14] Bounds register holds scan start index in bits 11:8
// [R15] Bounds register holds scan end index in bits 3:0
// [R16] Index increments after every port read or write
// [R17] Scan walks circularly from start to end, wrapping 15 to 0
// [R18] Each entry compared low then high, 10-bit compares, repeatedly
// [R19] Wait 120 clocks after enable; stop when enable cleared
// [R20] Interrupt is OR of enabled flags; flags stay set on recurring trips
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
module qtm_monitor
  import qtm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [9:0] sample,
  output logic [3:0] input_number,
  output logic pair_input_select,
  output logic input_invalid,
  output logic sample_active,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [9:0] low_thr_q [16];
  logic [9:0] high_thr_q [16];
  logic [4:0] list_q [16];
  logic scan_enable_q, scan_enable_d;
  logic list_access_select_q, list_access_select_d;
  logic low_high_select_q, low_high_select_d;
  logic [3:0] entry_index_q, entry_index_d;
  logic [3:0] first_entry_q, first_entry_d;
  logic [3:0] last_entry_q, last_entry_d;
  logic [15:0] rdata_q, rdata_d;
  qtm_state_type state_q, state_d;
  logic [6:0] wait_q, wait_d;
  logic [3:0] scan_ptr_q, scan_ptr_d;
  logic [3:0] input_number_q, input_number_d;
  logic pair_q, pair_d, invalid_q, invalid_d, active_q, active_d;
  logic irq_q;
  logic [15:0] low_set, high_set;
  logic [15:0] low_lo_val, high_lo_val, low_hi_val, high_hi_val;
  logic [3:0] irq_bank;
  logic port_access;
  logic [15:0] port_word;

  assign port_access = (wr | rd) && addr == ADDR_PORT;

  ////////////////////////////////////////////////////////////////////////////
  // Control, bounds and index registers
  always_comb begin
    scan_enable_d = scan_enable_q;
    list_access_select_d = list_access_select_q;
    low_high_select_d = low_high_select_q;
    entry_index_d = entry_index_q;
    first_entry_d = first_entry_q;
    last_entry_d = last_entry_q;
    if (wr && addr == ADDR_CONTROL) begin
      scan_enable_d = wdata[CTL_ENABLE_BIT];
      list_access_select_d = wdata[CTL_LIST_BIT];
      low_high_select_d = wdata[CTL_LOWHIGH_BIT];
      entry_index_d = wdata[CTL_INDEX_LSB +: 4];
    end
    if (wr && addr == ADDR_BOUNDS) begin
      first_entry_d = wdata[BOUNDS_FIRST_LSB +: 4]; // [R14]
      last_entry_d = wdata[BOUNDS_LAST_LSB +: 4]; // [R15]
    end
    if (port_access) begin
      entry_index_d = entry_index_q + 4'h1; // [R16]
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scan_enable_q <= 1'b0;
      list_access_select_q <= 1'b0;
      low_high_select_q <= 1'b0;
      entry_index_q <= 4'h0;
      first_entry_q <= 4'h0;
      last_entry_q <= 4'h0;
    end else begin
      scan_enable_q <= scan_enable_d;
      list_access_select_q <= list_access_select_d;
      low_high_select_q <= low_high_select_d;
      entry_index_q <= entry_index_d;
      first_entry_q <= first_entry_d;
      last_entry_q <= last_entry_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indirect arrays, written through the port
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        low_thr_q[i] <= 10'h000;
        high_thr_q[i] <= 10'h000;
        list_q[i] <= 5'h00;
      end
    end else if (wr && addr == ADDR_PORT) begin
      if (list_access_select_q) begin // [R1]
        list_q[entry_index_q] <= wdata[ENTRY_WIDTH-1:0]; // [R4] [R5]
      end else if (low_high_select_q) begin // [R2]
        high_thr_q[entry_index_q] <= wdata[THR_WIDTH-1:0]; // [R3]
      end else begin
        low_thr_q[entry_index_q] <= wdata[THR_WIDTH-1:0]; // [R3]
      end
    end
  end

  // Port read word, upper bits zero
  always_comb begin
    if (list_access_select_q) begin // [R1]
      port_word = {11'h000, list_q[entry_index_q]};
    end else if (low_high_select_q) begin // [R2]
      port_word = {6'h00, high_thr_q[entry_index_q]}; // [R3]
    end else begin
      port_word = {6'h00, low_thr_q[entry_index_q]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trip banks
  qtm_trip_bank u_low_lower (.clk(clk), .reset(reset), .wr(wr && addr == ADDR_LOW_LOWER), .wdata(wdata),
    .hw_set(low_set[7:0]), .value(low_lo_val), .irq(irq_bank[0])); // [R6] [R7]
  qtm_trip_bank u_high_lower (.clk(clk), .reset(reset), .wr(wr && addr == ADDR_HIGH_LOWER), .wdata(wdata),
    .hw_set(high_set[7:0]), .value(high_lo_val), .irq(irq_bank[1])); // [R8] [R9]
  qtm_trip_bank u_low_upper (.clk(clk), .reset(reset), .wr(wr && addr == ADDR_LOW_UPPER), .wdata(wdata),
    .hw_set(low_set[15:8]), .value(low_hi_val), .irq(irq_bank[2])); // [R10]
  qtm_trip_bank u_high_upper (.clk(clk), .reset(reset), .wr(wr && addr == ADDR_HIGH_UPPER), .wdata(wdata),
    .hw_set(high_set[15:8]), .value(high_hi_val), .irq(irq_bank[3])); // [R11]

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after strobe
  always_comb begin
    rdata_d = RESET_WORD;
    if (rd) begin
      unique case (addr)
        ADDR_CONTROL: rdata_d = {3'h0, scan_enable_q, 4'h0, list_access_select_q, 2'h0,
                                 low_high_select_q, entry_index_q};
        ADDR_PORT: rdata_d = port_word;
        ADDR_LOW_LOWER: rdata_d = low_lo_val;
        ADDR_HIGH_LOWER: rdata_d = high_lo_val;
        ADDR_LOW_UPPER: rdata_d = low_hi_val;
        ADDR_HIGH_UPPER: rdata_d = high_hi_val;
        ADDR_BOUNDS: rdata_d = {4'h0, first_entry_q, 4'h0, last_entry_q}; // [R15]
        default: rdata_d = RESET_WORD; // Unmapped reads zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan sequencer
  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    scan_ptr_d = scan_ptr_q;
    low_set = 16'h0000;
    high_set = 16'h0000;
    unique case (state_q)
      QTM_IDLE: begin
        if (scan_enable_q) begin
          state_d = QTM_WAKE;
          wait_d = 7'h01;
        end
      end
      QTM_WAKE: begin
        if (wait_q == WAKE_COUNT) begin // [R19]
          state_d = QTM_LOW;
          scan_ptr_d = first_entry_q;
        end else begin
          wait_d = wait_q + 7'h01;
        end
      end
      QTM_LOW: begin
        if (active_q && sample < low_thr_q[scan_ptr_q]) begin // [R18]
          low_set[scan_ptr_q] = 1'b1; // [R6]
        end
        state_d = QTM_HIGH;
      end
      QTM_HIGH: begin
        if (active_q && sample > high_thr_q[scan_ptr_q]) begin // [R18]
          high_set[scan_ptr_q] = 1'b1; // [R8]
        end
        state_d = QTM_LOW;
        if (scan_ptr_q == last_entry_q) begin
          scan_ptr_d = first_entry_q; // [R17]
        end else begin
          scan_ptr_d = scan_ptr_q + 4'h1; // [R17]
        end
      end
    endcase
    if (!scan_enable_q) begin
      state_d = QTM_IDLE; // [R19]
    end
  end

  // Input selection for the comparator
  always_comb begin
    input_number_d = list_q[scan_ptr_d][3:0]; // [R5]
    pair_d = list_q[scan_ptr_d][ENTRY_PAIR_BIT]; // [R4]
    invalid_d = pair_d && input_number_d[3]; // [R5]
    active_d = (state_d == QTM_LOW || state_d == QTM_HIGH) && !invalid_d;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= QTM_IDLE;
      wait_q <= 7'h00;
      scan_ptr_q <= 4'h0;
      rdata_q <= RESET_WORD;
      input_number_q <= 4'h0;
      pair_q <= 1'b0;
      invalid_q <= 1'b0;
      active_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      scan_ptr_q <= scan_ptr_d;
      rdata_q <= rdata_d;
      input_number_q <= input_number_d;
      pair_q <= pair_d;
      invalid_q <= invalid_d;
      active_q <= active_d;
      irq_q <= |irq_bank; // [R20]
    end
  end

  assign rdata = rdata_q;
  assign input_number = input_number_q;
  assign pair_input_select = pair_q;
  assign input_invalid = invalid_q;
  assign sample_active = active_q;
  assign irq = irq_q;
endmodule

//--- dv/qtm_monitor_chk.sv
// Purpose: Concurrent checks on the quick trip monitor ports
// Assumes: Bound to qtm_monitor, one clock domain
// Notes: Shadows control and bounds writes
`timescale 1ns/10ps
module qtm_monitor_chk
  import qtm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic [9:0] sample,
  input wire logic [3:0] input_number,
  input wire logic pair_input_select,
  input wire logic input_invalid,
  input wire logic sample_active,
  input wire logic irq
);
  logic ctl_wr;
  logic list_q;
  logic list_d;
  logic en_q;
  logic en_d;
  logic [15:0] bnd_q;
  logic [15:0] bnd_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  ////////////////////
  // Shadow state and wake counter
  always_comb begin
    ctl_wr = wr && addr == ADDR_CONTROL;
    list_d = ctl_wr ? wdata[CTL_LIST_BIT] : list_q;
    en_d = ctl_wr ? wdata[CTL_ENABLE_BIT] : en_q;
    bnd_d = (wr && addr == ADDR_BOUNDS) ? (wdata & 16'h0F0F) : bnd_q;
    cnt_d = (ctl_wr && wdata[CTL_ENABLE_BIT] && !en_q) ? 8'h00 : cnt_q + 8'(cnt_q != 8'hFF);
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      list_q <= 1'b0;
      en_q <= 1'b0;
      bnd_q <= 16'h0000;
      cnt_q <= 8'h00;
    end else begin
      list_q <= list_d;
      en_q <= en_d;
      bnd_q <= bnd_d;
      cnt_q <= cnt_d;
    end
  end
  ////////////////////
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_rd_only; rdata != 16'h0000 |-> $past(rd); endproperty
  a_rd_only: assert property (p_rd_only) else $error("read data outside read slot");
  property p_thr_zero; rd && addr == ADDR_PORT && !list_q |=> rdata[15:10] == 6'h00; endproperty
  a_thr_zero: assert property (p_thr_zero) else $error("threshold upper bits set");
  property p_lst_zero; rd && addr == ADDR_PORT && list_q |=> rdata[15:5] == 11'h000; endproperty
  a_lst_zero: assert property (p_lst_zero) else $error("list entry upper bits set");
  property p_bounds; rd && addr == ADDR_BOUNDS |=> rdata == bnd_q; endproperty
  a_bounds: assert property (p_bounds) else $error("bounds readback wrong");
  property p_unmapped; rd && addr == 3'h7 |=> rdata == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_sw_set; wr && addr == ADDR_LOW_LOWER && wdata[8] && wdata[0] |=> ##1 irq; endproperty
  a_sw_set: assert property (p_sw_set) else $error("software set gave no irq");
  property p_invalid; input_invalid |-> pair_input_select && input_number[3]; endproperty
  a_invalid: assert property (p_invalid) else $error("invalid flag on valid entry");
  property p_wake; sample_active |-> cnt_q >= 8'h78; endproperty
  a_wake: assert property (p_wake) else $error("compare before wake delay");
  property p_stop; ctl_wr && !wdata[CTL_ENABLE_BIT] |=> ##2 !sample_active; endproperty
  a_stop: assert property (p_stop) else $error("compare after disable");
  c_cmp: cover property (sample_active);
  c_irq: cover property (irq);
  c_inv: cover property (input_invalid);
endmodule

//--- dv/qtm_monitor_test.sv
// Purpose: Self-checking bench for the quick trip monitor
// Assumes: Comparator modelled by a table per input
// Notes: Random values from a fixed seed
`timescale 1ns/10ps
module qtm_monitor_test
  import qtm_pkg::*;
;
  logic clk;
  logic reset;
  logic [2:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic [9:0] sample;
  logic [3:0] input_number;
  logic pair_input_select;
  logic input_invalid;
  logic sample_active;
  logic irq;
  int miscompares;
  int samples_checked;
  int n;
  logic [9:0] lo [16];
  logic [9:0] hi [16];
  logic [4:0] lst [16];
  logic [9:0] vals [16];
  logic [15:0] d;
  logic [15:0] lt;
  logic [15:0] ht;
  ////////////////////
  // Clock and comparator model
  always #20 clk = ~clk;
  assign sample = vals[input_number];
  qtm_monitor u_qtm_monitor(.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sample(sample), .input_number(input_number), .pair_input_select(pair_input_select),
    .input_invalid(input_invalid), .sample_active(sample_active), .irq(irq));
  ////////////////////
  // Expectations and bus tasks
  function automatic logic [15:0] ent(input int m, input int i);
    if (m == 0) return {6'h00, lo[i]};
    if (m == 1) return {6'h00, hi[i]};
    return {11'h000, lst[i]};
  endfunction
  function automatic logic trip(input int e, input bit high);
    logic [9:0] v;
    v = vals[lst[e][3:0]];
    if ((e > 1 && e < 14) || (lst[e][4] && lst[e][3])) return 1'b0;
    return high ? v > hi[e] : v < lo[e];
  endfunction
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk16(what, exp, rdata);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////
  // Watchdog
  initial begin
    #2000000;
    miscompares++;
    summarize();
  end
  ////////////////////
  // Main sequence
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    addr = 3'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    void'($urandom(32'h303d));
    for (int i = 0; i < 16; i++) begin
      lo[i] = 10'($urandom);
      hi[i] = 10'($urandom);
      vals[i] = 10'($urandom);
      lst[i] = {1'b0, 4'(i)};
    end
    lst[0] = 5'h13;
    lst[15] = 5'h19;
    lo[14] = 10'h3FF;
    hi[14] = 10'h000;
    vals[14] = 10'h200;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 8; a++) rchk("reset_word", 3'(a), 16'h0000);
    for (int m = 0; m < 3; m++) begin
      wr_reg(ADDR_CONTROL, 16'(m == 2) << 7 | 16'(m == 1) << 4);
      for (int i = 0; i < 16; i++) wr_reg(ADDR_PORT, ent(m, i) | 16'hFC00);
      wr_reg(ADDR_CONTROL, 16'(m == 2) << 7 | 16'(m == 1) << 4);
      for (int i = 0; i < 16; i++) rchk("port_entry", ADDR_PORT, ent(m, i));
    end
    for (int a = 2; a < 6; a++) begin
      d = 16'($urandom);
      wr_reg(3'(a), d);
      rchk("trip_word", 3'(a), d);
      wr_reg(3'(a), 16'h0101);
      @(posedge clk);
      #1;
      chk1("irq_set", 1'b1, irq);
      wr_reg(3'(a), 16'h00FF);
      @(posedge clk);
      #1;
      chk1("irq_masked", 1'b0, irq);
      wr_reg(3'(a), 16'h0000);
    end
    wr_reg(ADDR_BOUNDS, 16'hFFFF);
    rchk("bounds", ADDR_BOUNDS, 16'h0F0F);
    wr_reg(ADDR_BOUNDS, 16'h0E01);
    wr_reg(ADDR_CONTROL, 16'h1000);
    for (n = 0; n < 200 && sample_active !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk1("scan_started", 1'b1, sample_active);
    // First entry selected, then the invalid pair entry skipped
    chk16("first_input", {12'h000, lst[14][3:0]}, {12'h000, input_number});
    chk1("first_pair", lst[14][4], pair_input_select);
    repeat (2) @(posedge clk);
    #1;
    chk16("next_input", {12'h000, lst[15][3:0]}, {12'h000, input_number});
    chk1("next_pair", lst[15][4], pair_input_select);
    chk1("next_invalid", lst[15][4] & lst[15][3], input_invalid);
    chk1("invalid_skipped", 1'b0, sample_active);
    repeat (100) @(posedge clk);
    wr_reg(ADDR_CONTROL, 16'h0000);
    repeat (4) @(posedge clk);
    for (int e = 0; e < 16; e++) begin
      lt[e] = trip(e, 1'b0);
      ht[e] = trip(e, 1'b1);
    end
    rchk("low_lower", ADDR_LOW_LOWER, {8'h00, lt[7:0]});
    rchk("high_lower", ADDR_HIGH_LOWER, {8'h00, ht[7:0]});
    rchk("low_upper", ADDR_LOW_UPPER, {8'h00, lt[15:8]});
    rchk("high_upper", ADDR_HIGH_UPPER, {8'h00, ht[15:8]});
    wr_reg(ADDR_LOW_UPPER, 16'h0000);
    rchk("flag_clear", ADDR_LOW_UPPER, 16'h0000);
    summarize();
  end
endmodule
bind qtm_monitor qtm_monitor_chk u_qtm_monitor_chk(.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .sample(sample), .input_number(input_number),
  .pair_input_select(pair_input_select), .input_invalid(input_invalid), .sample_active(sample_active), .irq(irq));
